// ### include/sysref_defs.svh
// How it works
// - Seven-bit coincidence divider gates pulse release.
// - Event starts by command or external edge.
// - Counted mode emits exactly 1 to 255 pulses.
// - Counted event ends and powers output down itself.
// - Mode bit: 0 counted, 1 continuous clock.
// - Rate divider picks ratio from 64 to 5120.
// - Mode and count are shared by all outputs.
// - Internal trigger: command loads count, starts pulses.
// - External trigger: command arms, rising edge starts.
// - Mode and count govern external events too.
// - Idle style 0 low, 1 crosspoint level.
// - Midpoint enable biases idle output, style 1 only.
// - Outputs turn on for event, off afterwards.
// - Pulses align to coincident channel clock edges.
// - Channel delay 256 whole steps, edges stay aligned.
// - Coarse reference delay eight half-steps.
// - Fine delay eight taps, 0 to 160 ps.
// - Global delay 256 whole steps, all outputs.
// - Bypass selects VCXO step instead of oscillator.
// - 180-degree setting inverts the channel clock.
// - Release command is a self-clearing strobe.
`ifndef SYSREF_DEFS_SVH
`define SYSREF_DEFS_SVH

// Oscillator step and its half, in picoseconds
`define STEP_PS          339
`define HALF_STEP_PS     169

// Rate ratios in oscillator steps, selected by rate code
`define RATE_64          13'h0040
`define RATE_96          13'h0060
`define RATE_128         13'h0080
`define RATE_192         13'h00C0
`define RATE_256         13'h0100
`define RATE_384         13'h0180
`define RATE_512         13'h0200
`define RATE_768         13'h0300
`define RATE_1024        13'h0400
`define RATE_2048        13'h0800
`define RATE_4096        13'h1000
`define RATE_5120        13'h1400

// Fine delay tap values in picoseconds
`define FINE_PS_0        8'h00
`define FINE_PS_1        8'h19
`define FINE_PS_2        8'h32
`define FINE_PS_3        8'h4B
`define FINE_PS_4        8'h55
`define FINE_PS_5        8'h6E
`define FINE_PS_6        8'h87
`define FINE_PS_7        8'hA0

// Extra history beyond the global delay for coarse whole steps
`define COARSE_SPAN      4

// Channel delay history, one entry per whole-step setting
`define CH_DLY_STEPS     256

`endif

// ### include/sysref_pkg.sv
package sysref_pkg;

    // Generator states, Gray coded along idle-armed-wait-run
    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_ARMED     = 2'b01,
        ST_WAIT_SYNC = 2'b11,
        ST_RUN       = 2'b10
    } gen_state_e;

endpackage

// ### rtl/sysref_pulse_generator.sv
`timescale 1ns/100ps
`default_nettype none
`include "sysref_defs.svh"

module sysref_pulse_generator #(
    parameter int NUM_CH  = 5,
    parameter int NUM_REF = 7,
    parameter int DLY_W   = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 osc_tick,
    input  wire logic                 vcxo_tick,
    input  wire logic                 second_loop_bypass,
    input  wire logic                 pulse_mode_select,
    input  wire logic [7:0]           pulse_count_value,
    input  wire logic                 trigger_source_select,
    input  wire logic                 release_command,
    input  wire logic                 external_trigger_input,
    input  wire logic [6:0]           sysref_rate_divider,
    input  wire logic [6:0]           sync_divider,
    input  wire logic [NUM_CH*8-1:0]  channel_divider,
    input  wire logic [NUM_CH*8-1:0]  channel_delay,
    input  wire logic [NUM_CH-1:0]    channel_clock_invert,
    input  wire logic [DLY_W-1:0]     global_delay,
    input  wire logic [NUM_REF*3-1:0] ref_coarse_delay,
    input  wire logic [NUM_REF*3-1:0] ref_fine_delay,
    input  wire logic                 idle_level_style,
    input  wire logic [NUM_REF-1:0]   idle_midpoint_enable,
    output logic [NUM_CH-1:0]         channel_clock_output,
    output logic [NUM_REF-1:0]        reference_pulse_output,
    output logic [NUM_REF-1:0]        ref_output_active,
    output logic [NUM_REF-1:0]        ref_output_powered,
    output logic [NUM_REF-1:0]        ref_idle_crosspoint,
    output logic [NUM_REF-1:0]        ref_half_step,
    output logic [NUM_REF*8-1:0]      ref_fine_delay_ps,
    output logic                      generator_armed,
    output logic                      generator_busy
);

    localparam int HIST = (1 << DLY_W) + `COARSE_SPAN;

    sysref_pkg::gen_state_e state_q;
    logic                   step_tick;
    logic [6:0]             sync_cnt_q;
    logic [6:0]             sync_limit;
    logic                   coincident;
    logic                   ext_prev_q;
    logic                   ext_rise;
    logic [7:0]             remain_q;
    logic [12:0]            rate_cnt_q;
    logic [12:0]            ratio;
    logic                   rate_wrap;
    logic                   last_pulse;
    logic                   raw_pulse;
    logic                   raw_active;
    logic                   in_run;
    logic                   in_armed;
    logic                   in_idle;
    logic                   count_empty;
    logic                   rate_restart;
    logic [HIST-1:0]        pulse_hist_q;
    logic [HIST-1:0]        act_hist_q;

    // Map the rate code to a ratio; unlisted codes fall back to the fastest rate
    function automatic logic [12:0] rate_ratio(input logic [6:0] code);
        logic [12:0] r;
        r = `RATE_64;
        case (code)
            7'h00: r = `RATE_64;
            7'h01: r = `RATE_96;
            7'h02: r = `RATE_128;
            7'h03: r = `RATE_192;
            7'h04: r = `RATE_256;
            7'h05: r = `RATE_384;
            7'h06: r = `RATE_512;
            7'h07: r = `RATE_768;
            7'h08: r = `RATE_1024;
            7'h09: r = `RATE_2048;
            7'h0A: r = `RATE_4096;
            7'h0B: r = `RATE_5120;
            default: r = `RATE_64;
        endcase
        return r;
    endfunction

    // Fine tap code to its nominal delay
    function automatic logic [7:0] fine_ps(input logic [2:0] tap);
        logic [7:0] p;
        p = `FINE_PS_0;
        case (tap)
            3'h0: p = `FINE_PS_0;
            3'h1: p = `FINE_PS_1;
            3'h2: p = `FINE_PS_2;
            3'h3: p = `FINE_PS_3;
            3'h4: p = `FINE_PS_4;
            3'h5: p = `FINE_PS_5;
            3'h6: p = `FINE_PS_6;
            default: p = `FINE_PS_7;
        endcase
        return p;
    endfunction

    // Step source: VCXO ticks when the second loop is bypassed
    assign step_tick = second_loop_bypass ? vcxo_tick : osc_tick;

    // Divider value zero behaves as divide-by-one
    assign sync_limit = (sync_divider == 7'h00) ? 7'h00 : sync_divider - 7'h01;
    assign coincident = step_tick && (sync_cnt_q == 7'h00);

    // Coincidence divider; software keeps it at the LCM of channel dividers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_cnt_q <= 7'h00;
        end else if (step_tick) begin
            sync_cnt_q <= (sync_cnt_q >= sync_limit) ? 7'h00 : sync_cnt_q + 7'h01;
        end
    end

    // External trigger edge; only edges seen while armed start an event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= external_trigger_input;
        end
    end

    // Rising edge only; a trigger already high when armed does not start
    assign ext_rise = external_trigger_input && !ext_prev_q;

    // Period length, wrap point and the last counted pulse
    assign ratio      = rate_ratio(sysref_rate_divider);
    assign rate_wrap  = step_tick && (rate_cnt_q == ratio - 13'h0001);
    assign last_pulse = !pulse_mode_select && (remain_q == 8'h01);

    // State decodes shared by the counters and the status flags
    assign in_run       = (state_q == sysref_pkg::ST_RUN);
    assign in_armed     = (state_q == sysref_pkg::ST_ARMED);
    assign in_idle      = (state_q == sysref_pkg::ST_IDLE);
    assign count_empty  = !pulse_mode_select && (remain_q == 8'h00);
    assign rate_restart = release_command || !in_run;

    // Event sequencer; release is a one-cycle strobe and always restarts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= sysref_pkg::ST_IDLE;
        end else if (release_command) begin
            state_q <= trigger_source_select ? sysref_pkg::ST_ARMED
                                             : sysref_pkg::ST_WAIT_SYNC;
        end else begin
            unique case (state_q)
                sysref_pkg::ST_IDLE: begin
                    state_q <= sysref_pkg::ST_IDLE;
                end
                sysref_pkg::ST_ARMED: begin
                    if (ext_rise) begin
                        state_q <= sysref_pkg::ST_WAIT_SYNC;
                    end
                end
                sysref_pkg::ST_WAIT_SYNC: begin
                    // A zero count in counted mode gives no pulses at all
                    if (coincident) begin
                        state_q <= count_empty ? sysref_pkg::ST_IDLE
                                               : sysref_pkg::ST_RUN;
                    end
                end
                sysref_pkg::ST_RUN: begin
                    if (rate_wrap && last_pulse) begin
                        state_q <= sysref_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Pulse budget, loaded on release and ignored in continuous mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remain_q <= 8'h00;
        end else if (release_command) begin
            remain_q <= pulse_count_value;
        end else if (in_run && rate_wrap && !pulse_mode_select) begin
            remain_q <= remain_q - 8'h01;
        end
    end

    // Rate counter, phase zero at the coincident edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_cnt_q <= 13'h0000;
        end else if (rate_restart) begin
            rate_cnt_q <= 13'h0000;
        end else if (step_tick) begin
            rate_cnt_q <= rate_wrap ? 13'h0000 : rate_cnt_q + 13'h0001;
        end
    end

    // High for the first half of each period
    assign raw_active = in_run;
    assign raw_pulse  = raw_active && (rate_cnt_q < (ratio >> 1));

    // Shared pulse history; one tap list serves all delays
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_hist_q <= '0;
        end else if (step_tick) begin
            pulse_hist_q <= {pulse_hist_q[HIST-2:0], raw_pulse};
        end
    end

    // Active history, delayed alongside the pulse so power follows the pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            act_hist_q <= '0;
        end else if (step_tick) begin
            act_hist_q <= {act_hist_q[HIST-2:0], raw_active};
        end
    end

    // Per-output delay taps and idle handling
    for (genvar r = 0; r < NUM_REF; r++) begin : g_ref
        logic [2:0] coarse;
        logic [8:0] tap;
        logic       act_t;
        assign coarse = ref_coarse_delay[r*3 +: 3];
        // Whole steps of global delay plus whole part of the coarse half-steps
        assign tap   = {1'b0, global_delay} + {7'h00, coarse[2:1]};
        assign act_t = act_hist_q[tap];

        // Delayed pulse level; held low once the delayed event is over
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                reference_pulse_output[r] <= 1'b0;
            end else begin
                reference_pulse_output[r] <= act_t && pulse_hist_q[tap];
            end
        end

        // Output switches on for the event and off after it
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ref_output_active[r] <= 1'b0;
            end else begin
                ref_output_active[r] <= act_t;
            end
        end

        // Midpoint bias keeps an idle output powered, only with style 1
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ref_output_powered[r] <= 1'b0;
            end else begin
                ref_output_powered[r] <= act_t ||
                                         (idle_level_style && idle_midpoint_enable[r]);
            end
        end

        // Crosspoint flag marks an idle output in style 1
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ref_idle_crosspoint[r] <= 1'b0;
            end else begin
                ref_idle_crosspoint[r] <= !act_t && idle_level_style;
            end
        end

        // A half step cannot be made at clock rate, so it is handed out
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ref_half_step[r] <= 1'b0;
            end else begin
                ref_half_step[r] <= coarse[0];
            end
        end

        // Fine tap as its nominal delay in picoseconds
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ref_fine_delay_ps[r*8 +: 8] <= `FINE_PS_0;
            end else begin
                ref_fine_delay_ps[r*8 +: 8] <= fine_ps(ref_fine_delay[r*3 +: 3]);
            end
        end
    end

    // Channel clocks; all dividers start together so rising edges coincide
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        localparam int CH_HIST = `CH_DLY_STEPS;
        logic [7:0]           div;
        logic [7:0]           cnt_q;
        logic [7:0]           lim;
        logic [CH_HIST-1:0]   hist_q;
        assign div = channel_divider[c*8 +: 8];
        assign lim = (div == 8'h00) ? 8'h00 : div - 8'h01;

        // Step counter of this channel, wrapping at its divider
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cnt_q <= 8'h00;
            end else if (step_tick) begin
                cnt_q <= (cnt_q >= lim) ? 8'h00 : cnt_q + 8'h01;
            end
        end

        // Undelayed clock history, high for the first half of each period
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                hist_q <= '0;
            end else if (step_tick) begin
                hist_q <= {hist_q[CH_HIST-2:0], (cnt_q < (div - (div >> 1)))};
            end
        end

        // Delay in whole steps, inversion gives the 180-degree setting
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                channel_clock_output[c] <= 1'b0;
            end else begin
                channel_clock_output[c] <= hist_q[channel_delay[c*8 +: 8]]
                                           ^ channel_clock_invert[c];
            end
        end
    end

    // Armed status, one cycle behind the sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            generator_armed <= 1'b0;
        end else begin
            generator_armed <= in_armed;
        end
    end

    // Busy covers armed and waiting too, so software sees any pending event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            generator_busy <= 1'b0;
        end else begin
            generator_busy <= !in_idle;
        end
    end

endmodule
`default_nettype wire

// ### verif/sysref_converter_model.sv
`timescale 1ns/100ps
`default_nettype none
// Converter end: counts reference rises and times the last high phase
module sysref_converter_model (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  sysref,
    input  wire logic  clr,
    output logic [15:0] rises,
    output logic [15:0] hi_len
);
    logic        prev_q;
    logic [15:0] run_q;
    // A clear wins so a restarted event is judged on its own
    always_ff @(posedge clk) begin
        prev_q <= sysref;
        if (!rst_n || clr) rises <= 16'h0000;
        else if (sysref && !prev_q) rises <= rises + 16'h0001;
    end
    // High phase length, latched at the falling edge
    always_ff @(posedge clk) begin
        run_q <= sysref ? run_q + 16'h0001 : 16'h0000;
        if (!sysref && prev_q) hi_len <= run_q;
    end
endmodule
`default_nettype wire

// ### verif/sysref_gen_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the reference pulse generator
module sysref_gen_properties #(
    parameter int NUM_REF = 7
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 release_command,
    input wire logic                 trigger_source_select,
    input wire logic                 external_trigger_input,
    input wire logic                 pulse_mode_select,
    input wire logic                 idle_level_style,
    input wire logic [NUM_REF-1:0]   idle_midpoint_enable,
    input wire logic [NUM_REF*3-1:0] ref_coarse_delay,
    input wire logic [NUM_REF*3-1:0] ref_fine_delay,
    input wire logic [NUM_REF-1:0]   reference_pulse_output,
    input wire logic [NUM_REF-1:0]   ref_output_active,
    input wire logic [NUM_REF-1:0]   ref_output_powered,
    input wire logic [NUM_REF-1:0]   ref_idle_crosspoint,
    input wire logic [NUM_REF-1:0]   ref_half_step,
    input wire logic [NUM_REF*8-1:0] ref_fine_delay_ps,
    input wire logic                 generator_armed,
    input wire logic                 generator_busy
);
    localparam logic [7:0] FINE_T [8] = '{8'h00, 8'h19, 8'h32, 8'h4B,
                                          8'h55, 8'h6E, 8'h87, 8'hA0};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_cmd_busy: assert property (release_command |-> ##2 generator_busy)
        else $error("busy missing after command");
    a_ext_arms: assert property (release_command && trigger_source_select |-> ##2 generator_armed)
        else $error("armed missing after command");
    a_arm_holds: assert property (generator_armed
        && $past(!external_trigger_input && !release_command) |=> generator_armed)
        else $error("armed dropped without edge");
    a_cont_runs: assert property (generator_busy && pulse_mode_select
        && $past(pulse_mode_select) |=> generator_busy)
        else $error("continuous event stopped");
    a_fine_map: assert property ($past(rst_n) |->
        ref_fine_delay_ps[7:0] == FINE_T[$past(ref_fine_delay[2:0])])
        else $error("fine delay value wrong");
    a_half_map: assert property ($past(rst_n) |-> ref_half_step[0] == $past(ref_coarse_delay[0]))
        else $error("half step wrong");
    a_idle_mid: assert property ($past(rst_n && idle_level_style) |->
        ref_idle_crosspoint == ~ref_output_active
        && ref_output_powered == (ref_output_active | $past(idle_midpoint_enable)))
        else $error("crosspoint idle wrong");
    a_idle_low: assert property ($past(rst_n && !idle_level_style) |->
        ref_idle_crosspoint == '0 && ref_output_powered == ref_output_active)
        else $error("low idle wrong");
    a_pulse_on: assert property ((reference_pulse_output & ~ref_output_active) == '0)
        else $error("pulse outside event");
endmodule
bind sysref_pulse_generator sysref_gen_properties #(.NUM_REF(NUM_REF)) chk (.*);
`default_nettype wire

// ### verif/sysref_pulse_generator_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %0d got %0d", nm, ex, got); end end
module sysref_pulse_generator_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, osc_tick = 1'b1, vcxo_tick = 1'b0, clr = 1'b0;
    logic        second_loop_bypass = 1'b0, pulse_mode_select = 1'b0, idle_level_style = 1'b0;
    logic        trigger_source_select = 1'b0, release_command = 1'b0;
    logic        external_trigger_input = 1'b0, generator_armed, generator_busy;
    logic [7:0]  pulse_count_value = 8'h01, global_delay = 8'h00, a, b, c;
    logic [6:0]  sysref_rate_divider = 7'h00, idle_midpoint_enable = 7'h00;
    logic [6:0]  reference_pulse_output, ref_output_active, ref_output_powered;
    logic [6:0]  ref_idle_crosspoint, ref_half_step;
    logic [4:0]  channel_clock_invert = 5'h00, channel_clock_output;
    logic [39:0] channel_delay = 40'h0000000000;
    logic [20:0] ref_coarse_delay = 21'h000000, ref_fine_delay = 21'h000000;
    logic [55:0] ref_fine_delay_ps;
    logic [15:0] rises, hi_len;
    int          n_fail = 0, num_checks = 0, t0, t1;

    // All channel dividers two, so a coincidence divider of two is their multiple
    sysref_pulse_generator DUT (.sync_divider(7'h02), .channel_divider({5{8'h02}}),
        .channel_delay(channel_delay), .*);
    sysref_converter_model PEER (.sysref(reference_pulse_output[0]), .*);

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        tick(20);
        rst_n <= 1'b1;
        tick(1);
    endtask
    // One-cycle command strobe; the model's count restarts with it
    task automatic fire();
        @(posedge clk);
        release_command <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        release_command <= 1'b0;
        clr <= 1'b0;
        tick(3);
    endtask
    // Extra cycles let the delay history drain after the generator goes idle
    task automatic wait_idle(int lim);
        for (int i = 0; i < lim && generator_busy !== 1'b0; i++) tick(1);
        if (generator_busy !== 1'b0) begin
            n_fail++;
            $display("BAD wait_idle exp 0 got 1");
            test_done();
        end
        tick(64);
    endtask
    // A used-up bound is a mismatch and ends the run at once
    task automatic give_up(string nm);
        n_fail++;
        $display("BAD %s exp done got timeout", nm);
        test_done();
    endtask
    task automatic first_rise(output int t);
        fire();
        for (t = 0; t < 600 && rises == 16'h0000; t++) tick(1);
        if (rises == 16'h0000) give_up("first_rise");
        wait_idle(2000);
    endtask

    task automatic t_counted();
        logic [7:0] cnt [3] = '{8'h01, 8'h03, 8'hFF};
        for (int k = 0; k < 3; k++) begin
            pulse_count_value <= cnt[k];
            fire();
            wait_idle(20000);
            `CHK("pulses", cnt[k], rises[7:0])
            `CHK("active", 7'h00, ref_output_active)
        end
        `CHK("high64", 16'h0020, hi_len)
    endtask
    // Every rate code and one unlisted code, a single pulse each
    task automatic t_rate();
        logic [15:0] half [13] = '{16'h0020, 16'h0030, 16'h0040, 16'h0060, 16'h0080, 16'h00C0,
            16'h0100, 16'h0180, 16'h0200, 16'h0400, 16'h0800, 16'h0A00, 16'h0020};
        pulse_count_value <= 8'h01;
        for (int k = 0; k < 13; k++) begin
            sysref_rate_divider <= (k < 12) ? 7'(k) : 7'h7F;
            fire();
            wait_idle(6000);
            `CHK("high", half[k], hi_len)
        end
        sysref_rate_divider <= 7'h00;
    endtask
    task automatic t_external();
        trigger_source_select <= 1'b1;
        pulse_count_value <= 8'h02;
        fire();
        tick(100);
        `CHK("armed", 1'b1, generator_armed)
        `CHK("early", 16'h0000, rises)
        external_trigger_input <= 1'b1;
        wait_idle(1000);
        `CHK("ext pulses", 16'h0002, rises)
        external_trigger_input <= 1'b0;
        trigger_source_select <= 1'b0;
    endtask
    task automatic t_restart();
        pulse_count_value <= 8'h04;
        fire();
        for (int i = 0; i < 300 && rises == 16'h0000; i++) tick(1);
        if (rises == 16'h0000) give_up("restart wait");
        tick(40);
        pulse_count_value <= 8'h02;
        fire();
        wait_idle(1000);
        `CHK("restart", 16'h0002, rises)
    endtask
    task automatic t_bypass();
        second_loop_bypass <= 1'b1;
        pulse_count_value <= 8'h01;
        fire();
        tick(200);
        `CHK("no steps", 16'h0000, rises)
        vcxo_tick <= 1'b1;
        wait_idle(1000);
        `CHK("vcxo steps", 16'h0001, rises)
        second_loop_bypass <= 1'b0;
    endtask
    task automatic t_idle();
        idle_level_style <= 1'b1;
        idle_midpoint_enable <= 7'h55;
        tick(3);
        `CHK("cross", 7'h7F, ref_idle_crosspoint)
        `CHK("mid", 7'h55, ref_output_powered)
        idle_level_style <= 1'b0;
        tick(3);
        `CHK("low", 7'h00, ref_idle_crosspoint | ref_output_powered)
        for (int k = 0; k < 8; k++) begin
            ref_fine_delay <= 21'(k);
            tick(2);
        end
    endtask
    task automatic t_continuous();
        pulse_mode_select <= 1'b1;
        fire();
        tick(400);
        `CHK("running", 1'b1, generator_busy)
        `CHK("clock", 1'b1, rises >= 16'h0005)
        `CHK("global", {7{reference_pulse_output[0]}}, reference_pulse_output)
        pulse_mode_select <= 1'b0;
    endtask
    // Each measurement starts from reset so the step phase is identical
    task automatic t_delay();
        do_reset();
        first_rise(t0);
        global_delay <= 8'h29;
        do_reset();
        first_rise(t1);
        `CHK("global dly", 41, t1 - t0)
        global_delay <= 8'h00;
        ref_coarse_delay <= 21'h000002;
        do_reset();
        first_rise(t1);
        `CHK("coarse dly", 1, t1 - t0)
    endtask
    // Falling-edge samples see settled outputs; each run starts from reset
    task automatic t_invert();
        do_reset();
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            a[k] = channel_clock_output[0];
        end
        tick(1);
        channel_clock_invert <= 5'h1F;
        do_reset();
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            b[k] = channel_clock_output[0];
        end
        tick(1);
        channel_clock_invert <= 5'h00;
        channel_delay <= 40'h0000000001;
        do_reset();
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            c[k] = channel_clock_output[0];
        end
        tick(1);
        channel_delay <= 40'h0000000000;
        `CHK("toggles", 1'b1, a != 8'h00 && a != 8'hFF)
        `CHK("invert", ~a, b)
        `CHK("ch delay", a[6:0], c[7:1])
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        do_reset();
        t_counted();
        t_rate();
        t_external();
        t_restart();
        t_bypass();
        t_idle();
        t_continuous();
        t_delay();
        t_invert();
        test_done();
    end
endmodule
`default_nettype wire
